/* hw/spi_port_map.vh */
// Register map, field positions, mode codes and timing constants of the serial port.
`ifndef SPI_PORT_MAP_VH
`define SPI_PORT_MAP_VH

// ==========================================================================
// Register word offsets (byte addresses on the 32-bit bus)
`define OFS_SERIAL_STATUS      8'h00
`define OFS_SERIAL_CONTROL_ONE 8'h04
`define OFS_DATA_BUFFER        8'h08
`define OFS_RATE_RELOAD_VALUE  8'h0C
`define OFS_EVENT_FLAGS        8'h10

// ==========================================================================
// Field positions
`define ST_SAMPLE_PHASE_BIT    7
`define ST_CLOCK_EDGE_BIT      6
`define ST_BUFFER_FULL_BIT     0
`define C1_WRITE_COLL_BIT      7
`define C1_PORT_ENABLE_BIT     5
`define C1_CLOCK_POL_BIT       4
`define C1_MODE_HI             3
`define C1_MODE_LO             0
`define EV_PORT_FLAG_BIT       0

// ==========================================================================
// Reset values
`define RST_BYTE               8'h00

// ==========================================================================
// Role and rate codes of the mode field
`define MODE_MASTER_DIV4       4'h0
`define MODE_MASTER_DIV16      4'h1
`define MODE_MASTER_DIV64      4'h2
`define MODE_MASTER_TIMER      4'h3
`define MODE_SLAVE_SEL_ON      4'h4
`define MODE_SLAVE_SEL_OFF     4'h5
`define MODE_MASTER_RELOAD     4'hA

// ==========================================================================
// Half periods of the serial clock in system clocks, and bit timing
`define HALF_DIV4              10'h002
`define HALF_DIV16             10'h008
`define HALF_DIV64             10'h020
`define BITS_PER_BYTE          4'h8
`define LAST_BIT_INDEX         4'h7
`define EDGES_PER_BYTE         5'h10
`define EDGES_LATE_SAMPLE      5'h11
`define MIN_LATE_SAMPLE_EDGE   5'h02

`endif

/* hw/spi_rate_gen.v */
// Master serial clock rate generator: one pulse per half period of the serial clock.
`timescale 1ns/10ps
`include "spi_port_map.vh"

module spi_rate_gen (
	// Clock and reset.
	input  wire       clk,
	input  wire       rst_n,
	input  wire       ce,
	// Control.
	input  wire       run,
	input  wire [3:0] mode,
	input  wire [7:0] reload,
	input  wire       timer_tick,
	// Half-period pulse.
	output reg        half_tick
);
	reg  [9:0] cnt_ff;
	reg  [9:0] half_len;

	// Half period length for each divided rate; reload gives 2*(reload+1).
	always @* begin
		case (mode)
			`MODE_MASTER_DIV16:  half_len = `HALF_DIV16;
			`MODE_MASTER_DIV64:  half_len = `HALF_DIV64;
			`MODE_MASTER_RELOAD: half_len = {1'b0, reload, 1'b0} + `HALF_DIV4;
			default:             half_len = `HALF_DIV4;
		endcase
	end

	// Counter restarts whenever the master is idle so the first half period is full length.
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			cnt_ff    <= 10'h000;
			half_tick <= 1'b0;
		end else if (ce) begin
			if (!run) begin
				cnt_ff    <= 10'h000;
				half_tick <= 1'b0;
			end else if (mode == `MODE_MASTER_TIMER) begin
				half_tick <= timer_tick; // Timer output halved: one toggle per timer pulse.
			end else if (cnt_ff == half_len - 10'h001) begin
				cnt_ff    <= 10'h000;
				half_tick <= 1'b1;
			end else begin
				cnt_ff    <= cnt_ff + 10'h001;
				half_tick <= 1'b0;
			end
		end
	end
endmodule // spi_rate_gen

/* hw/spi_sck_edges.v */
// Leading and trailing edge detector for the serial clock seen by a slave.
`timescale 1ns/10ps

module spi_sck_edges (
	// Clock and reset.
	input  wire clk,
	input  wire rst_n,
	input  wire ce,
	// Clock pin and idle level.
	input  wire sck,
	input  wire idle_level,
	// Edge pulses.
	output reg  lead,
	output reg  trail
);
	reg prev_ff;

	// Leading edge leaves the idle level, trailing edge returns to it.
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			prev_ff <= 1'b0;
			lead    <= 1'b0;
			trail   <= 1'b0;
		end else if (ce) begin
			prev_ff <= sck;
			lead    <= (prev_ff == idle_level) && (sck != idle_level);
			trail   <= (prev_ff != idle_level) && (sck == idle_level);
		end
	end
endmodule // spi_sck_edges

/* hw/spi_serial_port.v */
// SPI serial port with Wishbone register access, master and slave roles.
//
// The address map and the Wishbone register port were left to the implementer.
`timescale 1ns/10ps
`include "spi_port_map.vh"

// Summary of operation
// - One byte per transfer, MSb first
// - Input bit enters LSb while MSb leaves
// - Output on programmed edge, capture opposite edge (master end sampling captures on output edge)
// - Full byte copies to buffer, sets flags
// - Buffer write loads shift register directly
// - Write during shifting dropped, collision flagged
// - Buffer read clears buffer-full flag
// - Master write starts clocking at once
// - Receive-only master still posts each byte
// - Master rate: /4, /16, /64, timer, reload
// - Edge bit set: first bit early
// - Control fields pick role, polarity, rate; status bits pick phase
// - Sample phase: middle or end of bit
// - Status low six bits read-only
// - Shift register only reached via buffer
// - Unselected slave ignores bus, stays off
// - Master stops clock when data ends
// - Slave flags on last captured bit
// - Select-controlled slave drives only while selected
// - Port reset zeroes the bit counter
module spi_serial_port (
	// System clock, reset and clock enable.
	input  wire        REF_CLK,
	input  wire        RST_N,
	input  wire        CE,
	// Wishbone slave.
	input  wire        WB_CYC_I,
	input  wire        WB_STB_I,
	input  wire        WB_WE_I,
	input  wire [7:0]  WB_ADR_I,
	input  wire [3:0]  WB_SEL_I,
	input  wire [31:0] WB_DAT_I,
	output reg  [31:0] WB_DAT_O,
	output reg         WB_ACK_O,
	// Timer pulse used as a rate source.
	input  wire        TIMER_TICK,
	// Serial clock pin.
	input  wire        SCK_I,
	output reg         SCK_O,
	output reg         SCK_OE,
	// Serial data pins and slave select.
	input  wire        SDI,
	output reg         SDO,
	output reg         SDO_OE,
	input  wire        SS_N
);
	// ==========================================================================
	// Registers
	// All state below sits behind the clock enable; nothing moves while CE is low,
	// which also freezes a half-sent byte and the serial clock at their levels.
	reg  [7:0]  serial_status_ff;    // Only the two writable upper bits are stored.
	reg  [7:0]  serial_control_one_ff;
	reg  [7:0]  data_buffer_ff;
	reg  [7:0]  rate_reload_value_ff;
	reg         buffer_full_ff;
	reg         port_flag_ff;
	reg         write_coll_ff;
	reg  [7:0]  shift_register_ff;
	reg  [3:0]  bit_cnt_ff;
	reg  [4:0]  half_cnt_ff;
	reg         running_ff;

	// ==========================================================================
	// Decoded configuration
	wire [3:0]  mode      = serial_control_one_ff[`C1_MODE_HI:`C1_MODE_LO];
	wire        enabled   = serial_control_one_ff[`C1_PORT_ENABLE_BIT];
	wire        clk_pol   = serial_control_one_ff[`C1_CLOCK_POL_BIT];
	wire        clk_edge  = serial_status_ff[`ST_CLOCK_EDGE_BIT];
	wire        late_smp  = serial_status_ff[`ST_SAMPLE_PHASE_BIT];

	// Master role is every code that is not one of the two slave codes.
	// Unlisted codes therefore behave as a master at the fastest divided rate,
	// so a stray configuration still produces a bounded, well-formed byte.
	function is_slave;
		input [3:0] m;
		begin
			is_slave = (m == `MODE_SLAVE_SEL_ON) || (m == `MODE_SLAVE_SEL_OFF);
		end
	endfunction

	wire        master    = enabled && !is_slave(mode);
	wire        slave     = enabled && is_slave(mode);
	// A select-controlled slave is only alive while select is low.
	wire        sel_gate  = (mode != `MODE_SLAVE_SEL_ON) || !SS_N;
	wire        slave_on  = slave && sel_gate;
	wire        slave_rst = slave && !sel_gate;

	// ==========================================================================
	// Bus decode
	// Only byte lane zero carries a register, so only its enable gates writes.
	// A request is never taken while its own ack stands, so it acts once.
	wire        bus_req   = WB_CYC_I && WB_STB_I && !WB_ACK_O;
	wire        bus_wr    = bus_req && WB_WE_I && WB_SEL_I[0];
	wire        bus_rd    = bus_req && !WB_WE_I;
	wire        wr_status = bus_wr && (WB_ADR_I == `OFS_SERIAL_STATUS);
	wire        wr_ctrl   = bus_wr && (WB_ADR_I == `OFS_SERIAL_CONTROL_ONE);
	wire        wr_buf    = bus_wr && (WB_ADR_I == `OFS_DATA_BUFFER);
	wire        wr_reload = bus_wr && (WB_ADR_I == `OFS_RATE_RELOAD_VALUE);
	wire        wr_flags  = bus_wr && (WB_ADR_I == `OFS_EVENT_FLAGS);
	wire        rd_buf    = bus_rd && (WB_ADR_I == `OFS_DATA_BUFFER);

	// The port counts as shifting while the master clocks or a slave is mid-byte.
	// Limitation: a slave without select control that loses a clock pulse stays
	// mid-byte, refusing buffer writes, until software clears the enable bit.
	wire        busy      = running_ff || (bit_cnt_ff != 4'h0);
	wire        load_ok   = wr_buf && enabled && !busy && !write_coll_ff;
	wire        collide   = wr_buf && enabled && busy;

	// ==========================================================================
	// Rate generator and slave clock edges
	// The generator restarts on every start so each byte opens with a full half period, except at the timer rate.
	wire        half_tick;
	wire        sck_lead;
	wire        sck_trail;

	spi_rate_gen u_rate (
		.clk        (REF_CLK),
		.rst_n      (RST_N),
		.ce         (CE),
		.run        (running_ff),
		.mode       (mode),
		.reload     (rate_reload_value_ff),
		.timer_tick (TIMER_TICK),
		.half_tick  (half_tick)
	);

	spi_sck_edges u_edges (
		.clk        (REF_CLK),
		.rst_n      (RST_N),
		.ce         (CE),
		.sck        (SCK_I),
		.idle_level (clk_pol),
		.lead       (sck_lead),
		.trail      (sck_trail)
	);

	// ==========================================================================
	// Master edge schedule: half periods are numbered 1..16, odd ones lead.
	// With late sampling and output on leading edges the eighth sample needs
	// a seventeenth half period, which does not toggle the clock.
	wire [4:0]  half_nxt  = half_cnt_ff + 5'h01;
	wire [4:0]  last_half = (late_smp && !clk_edge) ? `EDGES_LATE_SAMPLE : `EDGES_PER_BYTE;
	wire        m_tick    = master && running_ff && half_tick;
	wire        m_out_par = clk_edge ? !half_nxt[0] : half_nxt[0];
	wire        m_toggle  = m_tick && (half_nxt <= `EDGES_PER_BYTE);
	wire        m_out     = m_toggle && m_out_par;
	// Middle sampling uses the other edge; end sampling uses the next output edge.
	wire        m_sample  = m_tick && (late_smp ?
		(m_out_par && (half_nxt >= `MIN_LATE_SAMPLE_EDGE)) :
		(!m_out_par && (half_nxt <= `EDGES_PER_BYTE)));
	wire        m_done    = m_tick && (half_nxt == last_half);

	// Slave edges: with the edge bit set data changes on the trailing edge.
	// The pin is taken as synchronous, and each edge is acted on two system
	// clocks after it appears; an outside clock must therefore hold each level
	// for more than two system clocks, or bits are missed.
	wire        s_out     = slave_on && (clk_edge ? sck_trail : sck_lead);
	wire        s_sample  = slave_on && (clk_edge ? sck_lead : sck_trail);

	wire        do_sample = m_sample || s_sample;
	wire        do_out    = m_out || s_out;
	wire [7:0]  sr_shift  = {shift_register_ff[6:0], SDI};
	// Slave posts on its eighth capture, master when its last half period ends.
	wire        s_done    = s_sample && (bit_cnt_ff == `LAST_BIT_INDEX);
	wire        rx_done   = m_done || s_done;
	wire [7:0]  rx_byte   = do_sample ? sr_shift : shift_register_ff;

	// ==========================================================================
	// Shift register, bit counter and serial output.
	// Software never addresses the shift register; it is loaded only through
	// a buffer write and read only through the buffer copy.
	always @(posedge REF_CLK or negedge RST_N) begin
		if (!RST_N) begin
			shift_register_ff <= `RST_BYTE;
			bit_cnt_ff        <= 4'h0;
			SDO               <= 1'b0;
		end else if (CE) begin
			if (!enabled || slave_rst) begin
				bit_cnt_ff <= 4'h0;
			end else if (load_ok) begin
				shift_register_ff <= WB_DAT_I[7:0];
				SDO               <= WB_DAT_I[7];
				bit_cnt_ff        <= 4'h0;
			end else begin
				if (do_sample) begin
					shift_register_ff <= sr_shift;
					if (bit_cnt_ff == `LAST_BIT_INDEX) begin
						bit_cnt_ff <= 4'h0;
					end else begin
						bit_cnt_ff <= bit_cnt_ff + 4'h1;
					end
				end
				// When output and capture share an edge the next bit is one lower.
				if (do_out) begin
					SDO <= do_sample ? shift_register_ff[6] : shift_register_ff[7];
				end
			end
		end
	end

	// ==========================================================================
	// Master sequencing: a buffer write starts the clock, the last half
	// period stops it and parks the line back at the idle level.
	always @(posedge REF_CLK or negedge RST_N) begin
		if (!RST_N) begin
			running_ff  <= 1'b0;
			half_cnt_ff <= 5'h00;
			SCK_O       <= 1'b0;
		end else if (CE) begin
			if (!master) begin
				running_ff  <= 1'b0;
				half_cnt_ff <= 5'h00;
				SCK_O       <= clk_pol;
			end else if (load_ok) begin
				running_ff  <= 1'b1;
				half_cnt_ff <= 5'h00;
				SCK_O       <= clk_pol;
			end else if (running_ff) begin
				if (m_toggle) begin
					SCK_O <= !SCK_O;
				end
				if (m_tick) begin
					half_cnt_ff <= half_nxt;
				end
				if (m_done) begin
					running_ff <= 1'b0;
				end
			end else begin
				SCK_O <= clk_pol;
			end
		end
	end

	// ==========================================================================
	// Pin drive enables are registered like every other pin, so they follow
	// select and configuration changes one clock later.
	// Pin drive enables. The data output runs in every master mode even when
	// only receiving; an outside direction setting may override it.
	always @(posedge REF_CLK or negedge RST_N) begin
		if (!RST_N) begin
			SCK_OE <= 1'b0;
			SDO_OE <= 1'b0;
		end else if (CE) begin
			SCK_OE <= master;
			SDO_OE <= master || slave_on;
		end
	end

	// ==========================================================================
	// The port and collision flags are cleared by software writing zero, so a read-modify-write that
	// races a new completion can wipe a flag it never saw set.
	// Receive buffer and status flags. A hardware set in the same cycle as a
	// software clear wins, so no completion is lost.
	always @(posedge REF_CLK or negedge RST_N) begin
		if (!RST_N) begin
			data_buffer_ff <= `RST_BYTE;
			buffer_full_ff <= 1'b0;
			port_flag_ff   <= 1'b0;
			write_coll_ff  <= 1'b0;
		end else if (CE) begin
			// The buffer is overwritten even while still full.
			if (rx_done) begin
				data_buffer_ff <= rx_byte;
			end else if (load_ok) begin
				data_buffer_ff <= WB_DAT_I[7:0];
			end
			if (rx_done) begin
				buffer_full_ff <= 1'b1;
			end else if (rd_buf) begin
				buffer_full_ff <= 1'b0;
			end
			if (rx_done) begin
				port_flag_ff <= 1'b1;
			end else if (wr_flags && !WB_DAT_I[`EV_PORT_FLAG_BIT]) begin
				port_flag_ff <= 1'b0;
			end
			if (collide) begin
				write_coll_ff <= 1'b1;
			end else if (wr_ctrl && !WB_DAT_I[`C1_WRITE_COLL_BIT]) begin
				write_coll_ff <= 1'b0;
			end
		end
	end

	// ==========================================================================
	// Configuration registers. Only the upper two status bits take writes.
	always @(posedge REF_CLK or negedge RST_N) begin
		if (!RST_N) begin
			serial_status_ff      <= `RST_BYTE;
			serial_control_one_ff <= `RST_BYTE;
			rate_reload_value_ff  <= `RST_BYTE;
		end else if (CE) begin
			if (wr_status) begin
				serial_status_ff <= {WB_DAT_I[7:6], 6'h00};
			end
			if (wr_ctrl) begin
				serial_control_one_ff <= WB_DAT_I[7:0];
			end
			if (wr_reload) begin
				rate_reload_value_ff <= WB_DAT_I[7:0];
			end
		end
	end

	// ==========================================================================
	// Bus answer: one wait state, ack lasts one cycle, unmapped reads give zero.
	// Read data is registered with the ack, so it stands exactly when the master
	// samples the ack and holds until the next read replaces it.
	always @(posedge REF_CLK or negedge RST_N) begin
		if (!RST_N) begin
			WB_ACK_O <= 1'b0;
			WB_DAT_O <= 32'h00000000;
		end else if (CE) begin
			WB_ACK_O <= bus_req;
			if (bus_rd) begin
				case (WB_ADR_I)
					`OFS_SERIAL_STATUS:      WB_DAT_O <= {24'h000000, serial_status_ff[7:6], 5'h00,
						buffer_full_ff};
					`OFS_SERIAL_CONTROL_ONE: WB_DAT_O <= {24'h000000, write_coll_ff,
						serial_control_one_ff[6:0]};
					`OFS_DATA_BUFFER:        WB_DAT_O <= {24'h000000, data_buffer_ff};
					`OFS_RATE_RELOAD_VALUE:  WB_DAT_O <= {24'h000000, rate_reload_value_ff};
					`OFS_EVENT_FLAGS:        WB_DAT_O <= {31'h00000000, port_flag_ff};
					default:                 WB_DAT_O <= 32'h00000000;
				endcase
			end
		end
	end
endmodule // spi_serial_port

/* tb/spi_serial_port_monitor.sv */
// Concurrent checks on the serial port's bus and pin behaviour.
`timescale 1ns/10ps

module spi_serial_port_monitor (
	// Clock and reset.
	input logic        REF_CLK,
	input logic        RST_N,
	input logic        CE,
	// Register bus.
	input logic        WB_CYC_I,
	input logic        WB_STB_I,
	input logic        WB_WE_I,
	input logic [7:0]  WB_ADR_I,
	input logic [31:0] WB_DAT_O,
	input logic        WB_ACK_O,
	// Serial pins.
	input logic        SCK_O,
	input logic        SCK_OE,
	input logic        SDO_OE,
	input logic        SS_N
);
	default clocking @(posedge REF_CLK); endclocking
	default disable iff (!RST_N);

	// ==========================================================
	// Bus answers: one ack per taken request, one cycle later.
	property p_ack_resp;
		WB_CYC_I && WB_STB_I && !WB_ACK_O && CE |=> WB_ACK_O;
	endproperty
	a_ack_resp: assert property (p_ack_resp) else $error("bus request not acknowledged");
	property p_ack_pulse;
		WB_ACK_O |=> !WB_ACK_O;
	endproperty
	a_ack_pulse: assert property (p_ack_pulse) else $error("ack longer than one cycle");
	property p_ack_cause;
		$rose(WB_ACK_O) |-> $past(WB_CYC_I) && $past(WB_STB_I);
	endproperty
	a_ack_cause: assert property (p_ack_cause) else $error("ack without request");
	// Read data: only the low byte carries a register, status low bits are fixed.
	property p_dat_upper;
		WB_ACK_O && !WB_WE_I |-> WB_DAT_O[31:8] == 24'h000000;
	endproperty
	a_dat_upper: assert property (p_dat_upper) else $error("upper read bits not zero");
	property p_status_ro;
		WB_ACK_O && !WB_WE_I && WB_ADR_I == 8'h00 |-> WB_DAT_O[5:1] == 5'h00;
	endproperty
	a_status_ro: assert property (p_status_ro) else $error("status spare bits set");
	property p_unmapped;
		WB_ACK_O && !WB_WE_I && WB_ADR_I == 8'h14 |-> WB_DAT_O == 32'h00000000;
	endproperty
	a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
	// The fastest rate still holds every serial clock level two cycles.
	property p_sck_half;
		SCK_OE && $changed(SCK_O) |=> !$changed(SCK_O);
	endproperty
	a_sck_half: assert property (p_sck_half) else $error("serial clock half period too short");
	// A deselected slave lets its data pin float within three cycles.
	property p_ss_release;
		$rose(SS_N) && SDO_OE && !SCK_OE |-> ##[1:3] !SDO_OE;
	endproperty
	a_ss_release: assert property (p_ss_release) else $error("data pin kept after deselect");

	c_master: cover property ($rose(SCK_OE));
	c_deselect: cover property ($rose(SS_N) && SDO_OE);
	c_status: cover property (WB_ACK_O && WB_ADR_I == 8'h00);
endmodule // spi_serial_port_monitor

bind spi_serial_port spi_serial_port_monitor u_mon (.REF_CLK, .RST_N, .CE, .WB_CYC_I, .WB_STB_I, .WB_WE_I,
	.WB_ADR_I, .WB_DAT_O, .WB_ACK_O, .SCK_O, .SCK_OE, .SDO_OE, .SS_N);

/* tb/spi_link_partner.sv */
// Far-side serial device: shifts a byte out while capturing one in.
`timescale 1ns/10ps

module spi_link_partner (
	// Clock and reset.
	input  logic       clk,
	input  logic       rst_n,
	// Serial line.
	input  logic       sck,
	input  logic       sel_n,
	input  logic       pol,
	input  logic       cke,
	input  logic       mosi,
	output logic       miso,
	// Bytes.
	input  logic [7:0] tx,
	output logic [7:0] rx
);
	logic [7:0] sr;
	logic       sck_q;
	logic       hold;
	wire        lead  = (sck != sck_q) && (sck != pol);
	wire        trail = (sck != sck_q) && (sck == pol);
	// With the edge bit set data changes on trailing edges and is captured on leading ones; otherwise the reverse.
	wire        out_e = cke ? trail : lead;
	wire        smp_e = cke ? lead : trail;

	// Captures and shifts on the sample edge, shows the next bit on the output edge; the released line toggles.
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			sr    <= 8'h00;
			rx    <= 8'h00;
			miso  <= 1'b0;
			sck_q <= 1'b0;
			hold  <= 1'b0;
		end else begin
			sck_q <= sck;
			if (sel_n) begin
				sr   <= tx;
				hold <= tx[7];
				miso <= ~miso;
			end else begin
				if (smp_e) begin
					rx <= {rx[6:0], mosi};
					sr <= {sr[6:0], 1'b0};
				end
				if (out_e) hold <= sr[7];
				miso <= out_e ? sr[7] : hold;
			end
		end
	end
endmodule // spi_link_partner

/* tb/spi_serial_port_tb.sv */
// Self-checking bench for the serial port: register access, master rates, collision, slave select.
`timescale 1ns/10ps

module spi_serial_port_tb;
	logic        clk = 1'b0, rst_n = 1'b0, cyc = 1'b0, stb = 1'b0, we = 1'b0, tick = 1'b0;
	logic        sck_drv = 1'b0, ss_n = 1'b1, pol_r = 1'b0, sck_q = 1'b0;
	logic [7:0]  adr = 8'h00, ptx_r = 8'h00, st_r = 8'h40, prx, rq;
	logic [31:0] dat_i = 32'h0, dat_o;
	logic        ack, sck_o, sck_oe, sdo, sdo_oe, miso;
	int          n_errors, n_tests, ntog, t1, t2, cc, tc;
	logic [7:0]  mc [5] = '{8'h20, 8'h31, 8'h22, 8'h33, 8'h2A};
	int          hh [5] = '{2, 8, 32, 6, 10};
	wire         sck_line = sck_oe ? sck_o : sck_drv;
	wire         sdo_line = sdo_oe ? sdo : 1'bz;

	spi_serial_port DUT (.REF_CLK(clk), .RST_N(rst_n), .CE(1'b1), .WB_CYC_I(cyc), .WB_STB_I(stb),
		.WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(4'hF), .WB_DAT_I(dat_i), .WB_DAT_O(dat_o),
		.WB_ACK_O(ack), .TIMER_TICK(tick), .SCK_I(sck_line), .SCK_O(sck_o), .SCK_OE(sck_oe),
		.SDI(miso), .SDO(sdo), .SDO_OE(sdo_oe), .SS_N(ss_n));
	spi_link_partner u_far (.clk(clk), .rst_n(rst_n), .sck(sck_line), .sel_n(ss_n), .pol(pol_r), .cke(st_r[6]),
		.mosi(sdo_line), .miso(miso), .tx(ptx_r), .rx(prx));

	// Clock, a timer pulse every six cycles, and a serial clock toggle counter.
	always #5 clk = ~clk;
	always @(posedge clk) begin
		tc <= (tc == 5) ? 0 : tc + 1;
		tick <= (tc == 5);
		cc++;
		if (sck_oe === 1'b1 && sck_o !== sck_q) begin
			ntog++;
			if (ntog == 1) t1 = cc;
			if (ntog == 2) t2 = cc;
		end
		sck_q <= sck_o;
	end

	// ==========================================================
	// Bus cycle, held until ack is sampled, then released for a cycle.
	task automatic wb(input logic w, input logic [7:0] a, input logic [7:0] d);
		int i;
		@(posedge clk);
		cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; dat_i <= {24'h0, d};
		for (i = 0; i < 50 && ack !== 1'b1; i++) @(posedge clk);
		if (ack !== 1'b1) n_errors++;
		rq = dat_o[7:0];
		cyc <= 1'b0; stb <= 1'b0; we <= 1'b0;
	endtask
	task automatic chk(input logic [7:0] s, input logic [7:0] e);
		n_tests++;
		if (s !== e) begin
			n_errors++;
			$display("unexpected at %0t: got %h expected %h", $time, s, e);
		end
	endtask
	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		wb(1'b0, a, 8'h00);
		chk(rq, e);
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		wb(1'b1, a, d);
	endtask
	// One master byte: reconfigure with the port off, select, send, wait for the flag, check all.
	task automatic run(input logic [7:0] c, tx, ptx, input int h, input logic coll);
		int i;
		wr(8'h00, st_r);
		wr(8'h04, c & 8'hDF);
		wr(8'h04, c);
		pol_r <= c[4]; ptx_r <= ptx;
		@(posedge clk) ss_n <= 1'b0;
		ntog = 0;
		wr(8'h08, tx);
		if (coll) wr(8'h08, 8'hFF);
		rq = 8'h00;
		for (i = 0; i < 400 && rq !== 8'h01; i++) wb(1'b0, 8'h10, 8'h00);
		chk(rq, 8'h01);
		chk(8'(ntog), 8'h10);
		chk(8'(t2 - t1), 8'(h));
		chk(8'(sck_o), 8'(c[4]));
		rd(8'h00, st_r | 8'h01);
		rd(8'h04, c | {coll, 7'h00});
		rd(8'h08, ptx);
		rd(8'h00, st_r);
		chk(prx, tx);
		wr(8'h10, 8'h00);
		@(posedge clk) ss_n <= 1'b1;
	endtask

	task automatic final_report;
		$display("comparisons %0d mismatches %0d", n_tests, n_errors);
		if (n_errors == 0 && n_tests > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	// Watchdog, far beyond the longest expected run.
	initial begin
		repeat (30000) @(posedge clk);
		n_errors++;
		final_report;
	end

	// ==========================================================
	// Main sequence.
	initial begin
		repeat (5) @(posedge clk);
		rst_n <= 1'b1;
		for (int i = 0; i <= 16; i += 4) rd(8'(i), 8'h00);
		rd(8'h14, 8'h00);
		wr(8'h00, 8'hFF);
		rd(8'h00, 8'hC0);
		wr(8'h00, 8'h40);
		wr(8'h0C, 8'h04);
		rd(8'h0C, 8'h04);
		for (int i = 0; i < 5; i++) run(mc[i], 8'hA5 ^ 8'(i * 17), 8'h3C + 8'(i * 29), hh[i], 1'b0);
		// Output on leading edges with end-of-bit sampling: the byte needs a seventeenth half period.
		st_r = 8'h80;
		run(8'h30, 8'h69, 8'hB4, 2, 1'b0);
		st_r = 8'h40;
		// A second write while shifting is lost, and later buffer writes are refused until the flag is cleared.
		run(8'h22, 8'h5A, 8'h96, 32, 1'b1);
		ntog = 0;
		wr(8'h08, 8'h77);
		repeat (80) @(posedge clk);
		chk(8'(ntog), 8'h00);
		wr(8'h04, 8'h22);
		rd(8'h04, 8'h22);
		// Slave with select control, clocked by the bench at sixteen cycles per bit.
		wr(8'h04, 8'h04);
		wr(8'h04, 8'h24);
		pol_r <= 1'b0; ptx_r <= 8'h5C;
		@(posedge clk) ss_n <= 1'b0;
		wr(8'h08, 8'hC3);
		repeat (8) begin
			repeat (8) @(posedge clk);
			sck_drv <= 1'b1;
			repeat (8) @(posedge clk);
			sck_drv <= 1'b0;
		end
		repeat (8) @(posedge clk);
		chk(8'(sdo_oe), 8'h01);
		rd(8'h10, 8'h01);
		rd(8'h08, 8'h5C);
		chk(prx, 8'hC3);
		@(posedge clk) ss_n <= 1'b1;
		repeat (4) @(posedge clk);
		chk(8'(sdo_oe), 8'h00);
		final_report;
	end
endmodule // spi_serial_port_tb
